/* File: verilog/vmpe_params.svh */
// constants of the video microcode pixel engine
// assumes inclusion by bare name from the package and the modules
// Behaviour
// - during visible picture fetch memory words into the internal shift register
// - each step with a target other than none routes shift-register bits into Y, A or B
// - taking bits and shifting are independent; same bits may feed several coefficients
// - a step holds target, take count and a separate shift count
// - target none and shift count zero are legal steps
// - four microcode steps per pixel, then no-ops up to the pixel width
// - up to 20 bits per pixel: Y 8 bits, A and B 6 bits
// - Y sets brightness, A and B drive the two chroma axes
// - no look-up table; coefficients come straight from pixel bits unless table select supplies chroma
// - program length counts steps and sets cycles per pixel; a stalled step adds cycles
// - table select takes chroma from table bits: U low four bits, V signed
`ifndef VMPE_PARAMS_SVH
`define VMPE_PARAMS_SVH
`define VMPE_SR_W 32
`define VMPE_WORD_W 16
`define VMPE_STEPS 4
`define VMPE_Y_W 8
`define VMPE_C_W 6
`define VMPE_TBL_W 4
`define VMPE_MIN_PLEN 4
`define VMPE_PLEN_W 4
// step word: target [9:8], take [7:4], shift [3:0]
`define VMPE_STEP_W 10
`define VMPE_TGT_POS 8
`define VMPE_TAKE_POS 4
`define VMPE_SHIFT_POS 0
`define VMPE_CNT_W 4
`endif

/* File: verilog/vmpe_pkg.sv */
// types of the video microcode pixel engine
// assumes vmpe_params.svh is on the include path
`include "vmpe_params.svh"
package vmpe_pkg;
   typedef enum logic [1:0] {
      VMPE_TGT_NONE = 2'b00,
      VMPE_TGT_Y = 2'b01,
      VMPE_TGT_A = 2'b10,
      VMPE_TGT_B = 2'b11
   } vmpe_tgt_t;
endpackage

/* File: verilog/vmpe_step.sv */
// decoder of one microcode step against the shift register
// assumes the caller holds shift register and fill count
`timescale 1ns/10ps
`default_nettype none
`include "vmpe_params.svh"
module vmpe_step
   import vmpe_pkg::*;
#(
   parameter int SR_W = `VMPE_SR_W
) (
   input wire logic [`VMPE_STEP_W-1:0] step,
   input wire logic [SR_W-1:0] sr,
   input wire logic [5:0] fill,
   output vmpe_tgt_t tgt,
   output logic [`VMPE_CNT_W-1:0] shift,
   output logic [`VMPE_Y_W-1:0] value,
   output logic ready
);
   logic [`VMPE_CNT_W-1:0] take;
   logic [SR_W-1:0] picked;
   always_comb begin
      tgt = vmpe_tgt_t'(step[`VMPE_TGT_POS +: 2]);
      take = step[`VMPE_TAKE_POS +: `VMPE_CNT_W];
      shift = step[`VMPE_SHIFT_POS +: `VMPE_CNT_W];
      // msb-first pick, right aligned; no palette stage
      if (take == 4'h0) begin
         picked = '0;
      end else begin
         picked = sr >> (6'(SR_W) - 6'(take));
      end
      value = picked[`VMPE_Y_W-1:0];
      // stall until enough bits are present for both take and shift
      ready = (fill >= 6'(take)) && (fill >= 6'(shift));
   end
endmodule
`default_nettype wire

/* File: verilog/vmpe_engine.sv */
// pixel unpacking microcode engine: memory words in, Y/A/B coefficients out
// assumes the fetch path holds each offered word on mem_valid until mem_req takes it
`timescale 1ns/10ps
`default_nettype none
`include "vmpe_params.svh"
module vmpe_engine
   import vmpe_pkg::*;
#(
   parameter int SR_W = `VMPE_SR_W,
   parameter int WORD_W = `VMPE_WORD_W
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic picture_active,
   input wire logic [`VMPE_PLEN_W-1:0] prog_len,
   input wire logic [`VMPE_STEPS*`VMPE_STEP_W-1:0] ucode,
   input wire logic chroma_table_select,
   input wire logic [`VMPE_TBL_W-1:0] u_table,
   input wire logic [`VMPE_TBL_W-1:0] v_table,
   output logic mem_req,
   input wire logic mem_valid,
   input wire logic [WORD_W-1:0] mem_data,
   output logic [`VMPE_Y_W-1:0] coef_y,
   output logic [`VMPE_C_W-1:0] coef_a,
   output logic [`VMPE_C_W-1:0] coef_b,
   output logic pixel_strobe
);
   // =====================================================
   // state
   typedef struct packed {
      logic [SR_W-1:0] sr;
      logic [5:0] fill;
      logic [`VMPE_PLEN_W-1:0] cnt;
      logic [`VMPE_Y_W-1:0] wy;
      logic [`VMPE_C_W-1:0] wa;
      logic [`VMPE_C_W-1:0] wb;
      logic [`VMPE_Y_W-1:0] oy;
      logic [`VMPE_C_W-1:0] oa;
      logic [`VMPE_C_W-1:0] ob;
      logic strobe;
   } vmpe_state_t;

   vmpe_state_t st_reg;
   vmpe_state_t st_next;

   // =====================================================
   // step decode
   logic [`VMPE_STEP_W-1:0] cur_step;
   vmpe_tgt_t tgt;
   logic [`VMPE_CNT_W-1:0] shift;
   logic [`VMPE_Y_W-1:0] value;
   logic step_ready;
   logic is_ucode;
   logic [`VMPE_PLEN_W-1:0] plen;
   logic advance;
   logic last;
   logic take_word;
   logic [5:0] fill_after;
   logic [SR_W-1:0] word_ext;

   // first four steps come from microcode, the rest are no-ops
   assign is_ucode = st_reg.cnt < `VMPE_PLEN_W'(`VMPE_STEPS);
   assign cur_step = is_ucode ? ucode[st_reg.cnt[1:0]*`VMPE_STEP_W +: `VMPE_STEP_W] : '0;
   // shorter programs cannot fit the four fixed steps
   assign plen = (prog_len < `VMPE_PLEN_W'(`VMPE_MIN_PLEN)) ?
      `VMPE_PLEN_W'(`VMPE_MIN_PLEN) : prog_len;

   vmpe_step #(.SR_W(SR_W)) u_step (
      .step(cur_step),
      .sr(st_reg.sr),
      .fill(st_reg.fill),
      .tgt(tgt),
      .shift(shift),
      .value(value),
      .ready(step_ready)
   );

   // refill as soon as a whole word fits even with no shift this cycle
   assign mem_req = picture_active && (st_reg.fill <= 6'(SR_W - WORD_W));
   assign take_word = mem_req && mem_valid;
   assign advance = picture_active && step_ready;
   // at-or-beyond, so a width lowered mid-pixel ends the pixel instead of wrapping
   assign last = advance && (st_reg.cnt >= plen - `VMPE_PLEN_W'(1));
   assign fill_after = advance ? st_reg.fill - 6'(shift) : st_reg.fill;
   assign word_ext = {mem_data, {(SR_W-WORD_W){1'b0}}};

   // =====================================================
   // next state
   always_comb begin
      st_next = st_reg;
      st_next.strobe = 1'b0;
      if (!picture_active) begin
         // leftover bits of a line never leak into the next one
         st_next.sr = '0;
         st_next.fill = '0;
         st_next.cnt = '0;
         // a pixel cut by the end of the picture leaves no partial coefficients
         st_next.wy = '0;
         st_next.wa = '0;
         st_next.wb = '0;
      end else begin
         if (advance) begin
            // take and shift are separate: take reads before shift
            case (tgt)
               VMPE_TGT_Y: st_next.wy = value;
               VMPE_TGT_A: st_next.wa = value[`VMPE_C_W-1:0];
               VMPE_TGT_B: st_next.wb = value[`VMPE_C_W-1:0];
               VMPE_TGT_NONE: st_next.wy = st_next.wy;
               default: st_next.wy = st_next.wy;
            endcase
            st_next.sr = st_reg.sr << shift;
            st_next.cnt = last ? '0 : st_reg.cnt + `VMPE_PLEN_W'(1);
         end
         if (take_word) begin
            st_next.sr = st_next.sr | (word_ext >> fill_after);
         end
         st_next.fill = fill_after + (take_word ? 6'(WORD_W) : 6'h00);
         if (last) begin
            st_next.oy = st_next.wy;
            if (chroma_table_select) begin
               // table U is always positive, table V sign extends
               st_next.ob = {2'b00, u_table};
               st_next.oa = {{2{v_table[3]}}, v_table};
            end else begin
               st_next.oa = st_next.wa;
               st_next.ob = st_next.wb;
            end
            st_next.strobe = 1'b1;
            st_next.wy = '0;
            st_next.wa = '0;
            st_next.wb = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign coef_y = st_reg.oy;
   assign coef_a = st_reg.oa;
   assign coef_b = st_reg.ob;
   assign pixel_strobe = st_reg.strobe;

   // =====================================================
   // checks
   sequence s_last_step;
      last;
   endsequence
   sequence s_strobe_next;
      ##1 pixel_strobe;
   endsequence

   chk_pixel_strobe: assert property (@(posedge clk) disable iff (!rst_b)
      s_last_step |-> s_strobe_next)
      else $error("strobe missing after last step");
   chk_strobe_cause: assert property (@(posedge clk) disable iff (!rst_b)
      pixel_strobe |-> $past(last))
      else $error("strobe without last step");
   chk_nop_steps: assert property (@(posedge clk) disable iff (!rst_b)
      (st_reg.cnt >= `VMPE_PLEN_W'(`VMPE_STEPS)) |-> (cur_step == '0))
      else $error("step beyond four not a no-op");
   chk_fill_bound: assert property (@(posedge clk) disable iff (!rst_b)
      st_reg.fill <= 6'(SR_W))
      else $error("shift register overfilled");
   chk_no_underrun: assert property (@(posedge clk) disable iff (!rst_b)
      advance |-> (st_reg.fill >= 6'(shift)))
      else $error("shift beyond remaining bits");
   chk_fetch_active: assert property (@(posedge clk) disable iff (!rst_b)
      mem_req |-> picture_active)
      else $error("fetch outside picture");
   chk_y_take: assert property (@(posedge clk) disable iff (!rst_b)
      (advance && !last && tgt == VMPE_TGT_Y) |=> (st_reg.wy == $past(value)))
      else $error("luminance not taken");
   chk_shift_only: assert property (@(posedge clk) disable iff (!rst_b)
      (advance && !take_word && picture_active) |=>
      (st_reg.sr == ($past(st_reg.sr) << $past(shift))))
      else $error("shift not independent of take");
   chk_table_u: assert property (@(posedge clk) disable iff (!rst_b)
      (last && chroma_table_select) |=> (coef_b == {2'b00, $past(u_table)}))
      else $error("table u not placed low");
   chk_fill_count: assert property (@(posedge clk) disable iff (!rst_b)
      (picture_active && take_word && !advance) |=>
      (st_reg.fill == $past(st_reg.fill) + 6'(WORD_W)))
      else $error("word not counted in fill");

   // coefficients move only with the strobe, so the modulator may sample any cycle
   chk_coef_hold: assert property (@(posedge clk) disable iff (!rst_b)
      !last |=> ($stable(coef_y) && $stable(coef_a) && $stable(coef_b)))
      else $error("coefficient changed without pixel end");
   chk_strobe_single: assert property (@(posedge clk) disable iff (!rst_b)
      pixel_strobe |=> !pixel_strobe)
      else $error("strobe longer than one cycle");
   // a starved step lengthens the pixel instead of using absent bits
   chk_stall_hold: assert property (@(posedge clk) disable iff (!rst_b)
      (picture_active && !step_ready) |=> $stable(st_reg.cnt))
      else $error("step advanced without enough bits");
   chk_line_flush: assert property (@(posedge clk) disable iff (!rst_b)
      !picture_active |=> (st_reg.fill == 6'h00 && st_reg.cnt == '0 && st_reg.wy == '0))
      else $error("state kept outside picture");
   chk_a_take: assert property (@(posedge clk) disable iff (!rst_b)
      (advance && !last && tgt == VMPE_TGT_A) |=>
      (st_reg.wa == $past(value[`VMPE_C_W-1:0])))
      else $error("chroma a not taken");
   chk_b_take: assert property (@(posedge clk) disable iff (!rst_b)
      (advance && !last && tgt == VMPE_TGT_B) |=>
      (st_reg.wb == $past(value[`VMPE_C_W-1:0])))
      else $error("chroma b not taken");
   chk_table_v: assert property (@(posedge clk) disable iff (!rst_b)
      (last && chroma_table_select) |=>
      (coef_a == {{2{$past(v_table[3])}}, $past(v_table)}))
      else $error("table v not sign extended");
   // word lands directly below the bits still waiting, msb first
   chk_word_append: assert property (@(posedge clk) disable iff (!rst_b)
      (take_word && !advance) |=>
      (st_reg.sr == ($past(st_reg.sr) | ($past(word_ext) >> $past(st_reg.fill)))))
      else $error("word not placed after remaining bits");
endmodule
`default_nettype wire

/* File: verif/vmpe_fetch_model.sv */
// far-side model of the video memory fetch path
// assumes the bench seeds the random generator once
`timescale 1ns/10ps
`default_nettype none
module vmpe_fetch_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic mem_req,
   input wire logic slow,
   output logic mem_valid,
   output logic [15:0] mem_data
);
   // ==========
   // word offer
   // offer held until taken; idle data toggles so a stale word never looks fresh
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_valid <= 1'b0;
         mem_data <= 16'h0000;
      end else if (!mem_valid || mem_req) begin
         mem_valid <= !slow || ($urandom_range(1) == 1);
         mem_data <= mem_valid ? 16'($urandom) : ~mem_data;
      end
   end
endmodule
`default_nettype wire

/* File: verif/tb_vmpe_engine.sv */
// bench: microcode runs compared with a bit-queue model of the pixel engine
// assumes vmpe_fetch_model supplies the memory words
`timescale 1ns/10ps
`default_nettype none
module tb_vmpe_engine;
   logic clk = 0, rst_b = 0, act = 0, slow = 0, tbl = 0, gap_en = 0, chk_en = 0;
   logic [3:0] plen = 4'h4, u_t = 4'h0, v_t = 4'h0;
   logic [39:0] uc = 40'h0;
   logic mem_req, mem_valid, pixel_strobe;
   logic [15:0] mem_data;
   logic [7:0] coef_y;
   logic [5:0] coef_a, coef_b;
   int n_fail = 0, n_compared = 0, n_pix = 0, gap = -1;
   bit bits[$];
   // ==========
   // clock, design and far side
   initial forever #5 clk = ~clk;
   vmpe_engine u_dut (.clk(clk), .rst_b(rst_b), .picture_active(act), .prog_len(plen),
      .ucode(uc), .chroma_table_select(tbl), .u_table(u_t), .v_table(v_t),
      .mem_req(mem_req), .mem_valid(mem_valid), .mem_data(mem_data), .coef_y(coef_y),
      .coef_a(coef_a), .coef_b(coef_b), .pixel_strobe(pixel_strobe));
   vmpe_fetch_model u_mem (.clk(clk), .rst_b(rst_b), .mem_req(mem_req), .slow(slow),
      .mem_valid(mem_valid), .mem_data(mem_data));
   task automatic chk(input bit ok, input string m);
      n_compared++;
      if (!ok) begin
         n_fail++;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ==========
   // model: words queued as bits, each pixel worked out at its strobe
   always @(posedge clk) begin
      int y, a, b, pos, k, t, v;
      if (mem_req && mem_valid)
         for (k = 15; k >= 0; k--) bits.push_back(mem_data[k]);
      if (pixel_strobe && chk_en) begin
         pos = 0; y = 0; a = 0; b = 0;
         for (k = 0; k < 4; k++) begin
            v = 0;
            for (t = 0; t < uc[10*k+4 +: 4]; t++) v = v * 2 + bits[pos+t];
            case (uc[10*k+8 +: 2])
               2'h1: y = v % 256;
               2'h2: a = v % 64;
               2'h3: b = v % 64;
               default: ;
            endcase
            pos += uc[10*k +: 4];
         end
         repeat (pos) void'(bits.pop_front());
         if (tbl) begin
            b = u_t;
            a = v_t[3] ? v_t + 48 : v_t;
         end
         chk(coef_y === 8'(y) && coef_a === 6'(a) && coef_b === 6'(b), "coefficients");
         if (gap_en && gap >= 0) chk(gap + 1 == ((plen < 4) ? 4 : plen), "pixel width");
         gap = 0;
         n_pix++;
      end else if (gap >= 0) gap++;
      if (!act) begin
         bits.delete();
         gap = -1;
      end
   end
   // ==========
   // scenarios
   task automatic run(input logic [39:0] u, input int pl, sl, tb, ge);
      int lim, target;
      @(posedge clk);
      chk_en <= 0;
      act <= 0;
      repeat (3) @(posedge clk);
      uc <= u;
      plen <= 4'(pl);
      slow <= sl[0];
      tbl <= tb[0];
      gap_en <= ge[0];
      u_t <= 4'($urandom);
      v_t <= 4'($urandom);
      @(posedge clk);
      act <= 1;
      chk_en <= 1;
      target = n_pix + 12;
      for (lim = 0; lim < 3000 && n_pix < target; lim++) @(posedge clk);
      chk(n_pix >= target, "pixel count");
   endtask
   initial begin
      logic [39:0] u;
      int i, k, r;
      void'($urandom(32'h70FE));
      repeat (16) @(posedge clk);
      rst_b <= 1;
      run({10'h010, 10'h133, 10'h263, 10'h362}, 4, 0, 0, 1);
      run({10'h010, 10'h133, 10'h263, 10'h362}, 11, 0, 1, 1);
      for (i = 0; i < 8; i++) begin
         r = $urandom_range(3);
         for (k = 0; k < 4; k++) u[10*k +: 10] = {2'((k + r) % 4), 8'($urandom)};
         run(u, $urandom_range(15), $urandom_range(1), i % 2, 0);
      end
      wrap_up;
   end
   initial begin
      #200us;
      n_fail++;
      wrap_up;
   end
endmodule
`default_nettype wire
